//--- hw/irq_ctrl_pkg.sv
// constants, register map and vector table of the vectored interrupt controller
// Operation
// - timer 3, events 1-3, rx, tx, converter, break take priorities 9-16, vectors to FFE0
// - each pin interrupt fires on a pin edge; direction per pin from misc bits 0-2
// - reset clears misc_control_one, so pin interrupts start on falling edges
// - pin detection always watches the shared port pins, whatever their current use
// - a timer request is raised one clock after its count reaches zero
// - event requests fire on the valid edge; polarity per event from control bits 0-2
// - host write strobe rising with chip select low captures bus and raises input-full
// - chip select, read and a0 low drive the output buffer; read rising raises empty
// - receive request when a word lands in the receive buffer, serial function selected
// - timing select 0: transmit request on buffer empty; 1: on shift complete
// - converter completion raises its request
// - break is lowest, has no enable, ignores inhibit, always taken
// - a break with requests pending runs the highest pending one instead
// - request bits set by sources, cleared on acceptance; software may clear, never set
// - each source except break has an enable bit; 0 blocks it, 1 allows it
// - inhibit flag is status bit 2, set and cleared by the two instructions
// - acceptance sets the inhibit flag automatically
// - maskable interrupt needs request, enable and inhibit clear, all independent
// - acceptance pushes program counter and status, loads the source vector
// - a request is accepted only when the current instruction completes
// - simultaneous requests: the higher fixed priority wins; reset is top, non-maskable
// - priorities 2-8: input-full, output-empty, three pins, timer 1, timer 2
package irq_ctrl_pkg;
   localparam int NSRC = 14;
   // source positions, highest priority first
   localparam int SRC_IN_FULL  = 0;
   localparam int SRC_OUT_EMPTY = 1;
   localparam int SRC_PIN0     = 2;
   localparam int SRC_TIMER0   = 5;
   localparam int SRC_EVENT0   = 8;
   localparam int SRC_RX       = 11;
   localparam int SRC_TX       = 12;
   localparam int SRC_ADC      = 13;
   // vector low addresses
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_FIRST = 16'hFFFC;
   localparam logic [15:0] VEC_BREAK = 16'hFFE0;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_MISC     = 10'h0DE;
   localparam logic [9:0] IDX_REQ_ONE  = 10'h0FC;
   localparam logic [9:0] IDX_REQ_TWO  = 10'h0FD;
   localparam logic [9:0] IDX_EN_ONE   = 10'h0E8;
   localparam logic [9:0] IDX_EN_TWO   = 10'h0E9;
   localparam logic [9:0] IDX_CTRL     = 10'h0EA;
   localparam logic [9:0] IDX_HOST_OUT = 10'h0EB;
   localparam logic [9:0] IDX_HOST_IN  = 10'h0EC;
   localparam logic [9:0] IDX_STATUS   = 10'h0ED;
   localparam logic [9:0] IDX_VEC_LO   = 10'h0EE;
   localparam logic [9:0] IDX_VEC_HI   = 10'h0EF;
   // control and status register fields
   localparam int CTRL_EVPOL_LSB = 0;
   localparam int CTRL_TX_TIMING = 3;
   localparam int CTRL_HOST_SEL  = 4;
   localparam int CTRL_SER_SEL   = 5;
   localparam int STATUS_INHIBIT = 2;
   // reset values
   localparam logic [7:0] MISC_RST = 8'h00;
   localparam logic [7:0] REQ_RST  = 8'h00;
   localparam logic [7:0] EN_RST   = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic       INH_RST  = 1'b1;
endpackage

//--- hw/vectored_interrupt_control.sv
// vectored fixed-priority interrupt controller with apb register access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module vectored_interrupt_control (
   input  wire logic        pclk,              // system clock, 20 MHz
   input  wire logic        presetn,           // asynchronous reset, active low
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb access phase
   input  wire logic        pwrite,            // apb direction, 1 = write
   input  wire logic [11:0] paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic      [31:0] prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr,           // apb error on unmapped address
   input  wire logic [2:0]  ext_pin,           // shared port pins, pin interrupts
   input  wire logic [2:0]  event_in,          // event inputs one to three
   input  wire logic        host_cs_n,         // host chip select, active low
   input  wire logic        host_wr_n,         // host write strobe, active low
   input  wire logic        host_rd_n,         // host read strobe, active low
   input  wire logic        host_a0,           // host address bit zero
   input  wire logic [7:0]  host_data_in,      // host data bus, pin level
   output logic      [7:0]  host_data_out,     // host data bus, driven value
   output logic             host_data_oe_n,    // host data bus enable, low drives
   input  wire logic [2:0]  timer_zero,        // timer count reached zero, pulse
   input  wire logic        rx_loaded,         // word moved into receive buffer, pulse
   input  wire logic        tx_buf_empty,      // transmit buffer emptied, pulse
   input  wire logic        tx_shift_done,     // transmit shifting complete, pulse
   input  wire logic        adc_done,          // conversion finished, pulse
   input  wire logic        instr_done,        // current instruction completes, pulse
   input  wire logic        software_break,    // break instruction, with instr_done
   input  wire logic        set_inhibit_instr, // set-inhibit instruction executes
   input  wire logic        clear_inhibit_instr, // clear-inhibit instruction executes
   output logic             irq_accept,        // push pc and status, load vector
   output logic      [15:0] vector_addr,       // low address of the accepted vector
   output logic             inhibit_flag       // status bit 2
);
   localparam int NS = irq_ctrl_pkg::NSRC;
   localparam int NPIN = 18;

   // ---------------- pin synchronisers ----------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_s3_q;

   assign pin_raw = {host_data_in, host_a0, host_rd_n, host_wr_n, host_cs_n, event_in, ext_pin};

   // first stage feeds only the second; edge logic compares stages two and three
   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_s1_q[g] <= 1'b1;
               pin_s2_q[g] <= 1'b1;
               pin_s3_q[g] <= 1'b1;
            end else begin
               pin_s1_q[g] <= pin_raw[g];
               pin_s2_q[g] <= pin_s1_q[g];
               pin_s3_q[g] <= pin_s2_q[g];
            end
         end
      end
   endgenerate

   wire [2:0] pin_now   = pin_s2_q[2:0];
   wire [2:0] pin_prev  = pin_s3_q[2:0];
   wire [2:0] ev_now    = pin_s2_q[5:3];
   wire [2:0] ev_prev   = pin_s3_q[5:3];
   wire       cs_prev_n = pin_s3_q[6];
   wire       wr_now_n  = pin_s2_q[7];
   wire       wr_prev_n = pin_s3_q[7];
   wire       rd_now_n  = pin_s2_q[8];
   wire       rd_prev_n = pin_s3_q[8];
   wire       a0_prev   = pin_s3_q[9];
   wire [7:0] data_prev = pin_s3_q[17:10];

   // ---------------- registers ----------------
   logic [7:0]    misc_q;
   logic [7:0]    en_one_q;
   logic [7:0]    en_two_q;
   logic [7:0]    ctrl_q;
   logic [7:0]    host_out_q;
   logic [7:0]    host_in_q;
   logic [NS-1:0] req_q;
   logic [NS-1:0] req_d;
   logic          inhibit_q;
   logic          inhibit_d;
   logic [2:0]    timer_zero_q;
   logic          accept_q;
   logic [15:0]   vector_q;
   logic [31:0]   prdata_q;

   // ---------------- apb decode ----------------
   wire [9:0] idx      = paddr[11:2];
   wire       setup    = psel & ~penable;
   wire       wr_acc   = psel & penable & pwrite;
   wire       hit_misc = (idx == irq_ctrl_pkg::IDX_MISC);
   wire       hit_r1   = (idx == irq_ctrl_pkg::IDX_REQ_ONE);
   wire       hit_r2   = (idx == irq_ctrl_pkg::IDX_REQ_TWO);
   wire       hit_e1   = (idx == irq_ctrl_pkg::IDX_EN_ONE);
   wire       hit_e2   = (idx == irq_ctrl_pkg::IDX_EN_TWO);
   wire       hit_ctrl = (idx == irq_ctrl_pkg::IDX_CTRL);
   wire       hit_hout = (idx == irq_ctrl_pkg::IDX_HOST_OUT);
   wire       hit_hin  = (idx == irq_ctrl_pkg::IDX_HOST_IN);
   wire       hit_stat = (idx == irq_ctrl_pkg::IDX_STATUS);
   wire       hit_vlo  = (idx == irq_ctrl_pkg::IDX_VEC_LO);
   wire       hit_vhi  = (idx == irq_ctrl_pkg::IDX_VEC_HI);
   wire       mapped   = hit_misc | hit_r1 | hit_r2 | hit_e1 | hit_e2 | hit_ctrl |
                         hit_hout | hit_hin | hit_stat | hit_vlo | hit_vhi;

   wire [7:0] rd_mux =
      hit_misc ? misc_q :
      hit_r1   ? req_q[7:0] :
      hit_r2   ? {2'b00, req_q[NS-1:8]} :
      hit_e1   ? en_one_q :
      hit_e2   ? {2'b00, en_two_q[5:0]} :
      hit_ctrl ? ctrl_q :
      hit_hout ? host_out_q :
      hit_hin  ? host_in_q :
      hit_stat ? {5'b00000, inhibit_q, 2'b00} :
      hit_vlo  ? vector_q[7:0] :
      hit_vhi  ? vector_q[15:8] : 8'h00;

   // read data is caught in the setup cycle so the access phase needs no wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= {24'h00_0000, rd_mux};
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ---------------- source events ----------------
   wire [2:0] pin_pol  = misc_q[2:0];
   wire [2:0] pin_evt  = (pin_pol & pin_now & ~pin_prev) |
                         (~pin_pol & ~pin_now & pin_prev);
   wire [2:0] ev_pol   = ctrl_q[irq_ctrl_pkg::CTRL_EVPOL_LSB +: 3];
   wire [2:0] ev_evt   = (ev_pol & ev_now & ~ev_prev) |
                         (~ev_pol & ~ev_now & ev_prev);
   wire       host_sel = ctrl_q[irq_ctrl_pkg::CTRL_HOST_SEL];
   wire       ser_sel  = ctrl_q[irq_ctrl_pkg::CTRL_SER_SEL];
   wire       hwr_evt  = host_sel & ~cs_prev_n & ~wr_now_n ? 1'b0 :
                         host_sel & ~cs_prev_n & wr_now_n & ~wr_prev_n;
   wire       hrd_evt  = host_sel & ~cs_prev_n & ~a0_prev & rd_now_n & ~rd_prev_n;
   wire       tx_evt   = ser_sel & (ctrl_q[irq_ctrl_pkg::CTRL_TX_TIMING] ?
                                    tx_shift_done : tx_buf_empty);
   wire       rx_evt   = ser_sel & rx_loaded;

   wire [NS-1:0] src_set = {adc_done, tx_evt, rx_evt, ev_evt, timer_zero_q,
                            pin_evt, hrd_evt, hwr_evt};

   // host read drive; enable is combinational from synchronised strobes
   assign host_data_oe_n = ~(host_sel & ~pin_s2_q[6] & ~rd_now_n & ~pin_s2_q[9]);
   assign host_data_out  = host_out_q;

   // ---------------- priority resolution ----------------
   wire [NS-1:0] en_all   = {en_two_q[5:0], en_one_q};
   wire [NS-1:0] eligible = req_q & en_all & {NS{~inhibit_q}};
   wire [NS-1:0] cand     = software_break ? req_q : eligible;
   logic [NS-1:0] win;
   logic [15:0]   win_vec;

   // lowest index wins: fixed hardware priority
   always_comb begin
      win     = '0;
      win_vec = irq_ctrl_pkg::VEC_BREAK;
      for (int i = NS - 1; i >= 0; i--) begin
         if (cand[i]) begin
            win     = '0;
            win[i]  = 1'b1;
            win_vec = irq_ctrl_pkg::VEC_FIRST - 16'(2 * i);
         end
      end
   end

   wire take = instr_done & (software_break | (|eligible));

   // ---------------- request and inhibit state ----------------
   wire          sw_r1 = wr_acc & hit_r1;
   wire          sw_r2 = wr_acc & hit_r2;
   wire [NS-1:0] sw_keep = {sw_r2 ? pwdata[5:0] : 6'h3F, sw_r1 ? pwdata[7:0] : 8'hFF};
   wire [NS-1:0] acc_clr = take ? win : '0;

   // a new request in the same cycle as its clear survives
   assign req_d = (req_q & sw_keep & ~acc_clr) | src_set;

   always_comb begin
      inhibit_d = inhibit_q;
      if (clear_inhibit_instr) begin
         inhibit_d = 1'b0;
      end
      if (set_inhibit_instr) begin
         inhibit_d = 1'b1;
      end
      if (take) begin
         inhibit_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q        <= '0;
         inhibit_q    <= irq_ctrl_pkg::INH_RST;
         timer_zero_q <= 3'b000;
      end else begin
         req_q        <= req_d;
         inhibit_q    <= inhibit_d;
         timer_zero_q <= timer_zero;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         misc_q     <= irq_ctrl_pkg::MISC_RST;
         en_one_q   <= irq_ctrl_pkg::EN_RST;
         en_two_q   <= irq_ctrl_pkg::EN_RST;
         ctrl_q     <= irq_ctrl_pkg::CTRL_RST;
         host_out_q <= 8'h00;
      end else if (wr_acc) begin
         if (hit_misc) misc_q <= pwdata[7:0];
         if (hit_e1) en_one_q <= pwdata[7:0];
         if (hit_e2) en_two_q <= pwdata[7:0];
         if (hit_ctrl) ctrl_q <= pwdata[7:0];
         if (hit_hout) host_out_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         host_in_q <= 8'h00;
      end else if (hwr_evt) begin
         host_in_q <= data_prev;
      end
   end

   // ---------------- acceptance ----------------
   // the core pushes pc and status on irq_accept, then fetches from vector_addr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accept_q <= 1'b0;
         vector_q <= irq_ctrl_pkg::VEC_RESET;
      end else begin
         accept_q <= take;
         if (take) vector_q <= win_vec;
      end
   end

   assign irq_accept   = accept_q;
   assign vector_addr  = vector_q;
   assign inhibit_flag = inhibit_q;

   // ---------------- assertions ----------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_boundary_take;
      instr_done && (software_break || (eligible != '0));
   endsequence

   sequence s_accept_out;
      irq_accept && inhibit_flag;
   endsequence

   a_accept_follows_take: assert property (
      s_boundary_take |=> s_accept_out)
      else $error("accepted request did not produce accept and inhibit");

   a_accept_needs_boundary: assert property (
      irq_accept |-> $past(instr_done))
      else $error("accept without instruction boundary");

   a_break_always_taken: assert property (
      (instr_done && software_break && inhibit_q && req_q == '0) |=>
         (irq_accept && vector_addr == 16'hFFE0))
      else $error("break not taken to its own vector");

   a_masked_blocked: assert property (
      (instr_done && !software_break && inhibit_q) |=> !irq_accept)
      else $error("interrupt taken while inhibit set");

   a_inhibit_after_take: assert property (
      irq_accept |-> inhibit_q)
      else $error("inhibit not set by acceptance");

   a_timer_one_late: assert property (
      (timer_zero[0] && !(instr_done && software_break)) |=> ##1 req_q[5])
      else $error("timer request not set one clock after zero");

   a_pin_fall_default: assert property (
      (!misc_q[0] && pin_prev[0] && !pin_now[0]) |=> req_q[2])
      else $error("falling pin edge missed");

   a_host_capture: assert property (
      hwr_evt |=> (host_in_q == $past(data_prev) && req_q[0]))
      else $error("host write not captured");

   a_sw_cannot_set: assert property (
      (src_set == '0) |=> (req_q & ~$past(req_q)) == '0)
      else $error("request bit set without a source");

   a_vector_in_table: assert property (
      irq_accept |-> (vector_addr[0] == 1'b0 && vector_addr >= 16'hFFE0 &&
                      vector_addr <= 16'hFFFC))
      else $error("vector outside table");

   a_break_serves_pending: assert property (
      (instr_done && software_break && req_q[13] && req_q[12:0] == '0) |=>
         (vector_addr == 16'hFFE2))
      else $error("break did not serve highest pending request");

endmodule // vectored_interrupt_control

//--- sim/core_model.sv
// behavioural processor core that issues instruction boundaries
`timescale 1ns/1ps
module core_model (
   input  wire logic       pclk,                // system clock
   input  wire logic       presetn,             // async reset, active low
   input  wire logic       go,                  // start one instruction
   input  wire logic [1:0] kind,                // 0 plain, 1 break, 2 set, 3 clear inhibit
   input  wire logic       slow,                // stretch the instruction
   output logic            instr_done,          // boundary pulse
   output logic            software_break,      // break with boundary
   output logic            set_inhibit_instr,   // set-inhibit executes
   output logic            clear_inhibit_instr, // clear-inhibit executes
   output logic            busy                 // instruction in flight
);
   logic [1:0] cnt_q;
   logic [1:0] kind_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {busy, cnt_q, kind_q} <= '0;
         {instr_done, software_break, set_inhibit_instr, clear_inhibit_instr} <= '0;
      end else begin
         {instr_done, software_break, set_inhibit_instr, clear_inhibit_instr} <= '0;
         if (go && !busy) begin
            busy   <= 1'h1;
            cnt_q  <= slow ? 2'h3 : 2'h0;
            kind_q <= kind;
         end else if (busy && cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
         end else if (busy) begin
            // one boundary per instruction, never in mid-instruction
            busy                <= 1'h0;
            instr_done          <= 1'h1;
            software_break      <= (kind_q == 2'h1);
            set_inhibit_instr   <= (kind_q == 2'h2);
            clear_inhibit_instr <= (kind_q == 2'h3);
         end
      end
   end
endmodule // core_model

//--- sim/test_vectored_interrupt_control.sv
// self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
module test_vectored_interrupt_control;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  ext_pin, event_in, timer_zero;
   logic        host_cs_n, host_wr_n, host_rd_n, host_a0, host_data_oe_n;
   logic [7:0]  host_data_in, host_data_out, out_byte, in_byte;
   logic        rx_loaded, tx_buf_empty, tx_shift_done, adc_done;
   logic        instr_done, software_break, set_inhibit_instr, clear_inhibit_instr;
   logic        irq_accept, inhibit_flag, go, slow, busy;
   logic [15:0] vector_addr;
   logic [1:0]  kind;
   int          num_errors, comparisons, seed;
   logic [32:0] rd_q[$];
   logic [15:0] vec_q[$];

   vectored_interrupt_control vectored_interrupt_control_inst (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_pin, .event_in,
      .host_cs_n, .host_wr_n, .host_rd_n, .host_a0, .host_data_in, .host_data_out,
      .host_data_oe_n, .timer_zero, .rx_loaded, .tx_buf_empty, .tx_shift_done, .adc_done,
      .instr_done, .software_break, .set_inhibit_instr, .clear_inhibit_instr, .irq_accept,
      .vector_addr, .inhibit_flag);
   core_model core_model_inst (.pclk, .presetn, .go, .kind, .slow, .instr_done,
      .software_break, .set_inhibit_instr, .clear_inhibit_instr, .busy);

   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end

   task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // read expectations carry {pslverr, prdata}
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                      input logic [32:0] exp);
      int n;
      n = 0;
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= {idx, 2'h0};
      pwdata <= {24'h0, d};
      if (!w) rd_q.push_back(exp);
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) num_errors++;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic exec(input logic [1:0] k);
      int n;
      n = 0;
      @(posedge pclk);
      go   <= 1'h1;
      kind <= k;
      slow <= 1'($random(seed));
      @(posedge pclk);
      go <= 1'h0;
      do begin
         @(posedge pclk);
         n++;
      end while (busy !== 1'h0 && n < 20);
      repeat (3) @(posedge pclk);
   endtask

   task automatic pulse(input logic [2:0] t, input logic [3:0] s);
      @(posedge pclk);
      timer_zero <= t;
      {rx_loaded, tx_buf_empty, tx_shift_done, adc_done} <= s;
      @(posedge pclk);
      timer_zero <= 3'h0;
      {rx_loaded, tx_buf_empty, tx_shift_done, adc_done} <= 4'h0;
      repeat (4) @(posedge pclk);
   endtask

   // strobes are synchronised, so each phase is held several clocks
   task automatic host(input logic rd);
      @(posedge pclk);
      host_cs_n <= 1'h0;
      host_a0   <= 1'h0;
      if (rd) host_rd_n <= 1'h0;
      else host_wr_n <= 1'h0;
      repeat (5) @(posedge pclk);
      check("oe_n", {32'h0, host_data_oe_n}, {32'h0, !rd});
      if (rd) check("host_out", {25'h0, host_data_out}, {25'h0, out_byte});
      host_rd_n <= 1'h1;
      host_wr_n <= 1'h1;
      repeat (5) @(posedge pclk);
      host_cs_n <= 1'h1;
      host_a0   <= 1'h1;
   endtask

   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         if (rd_q.size() == 0) check("read", 33'h0, 33'h1);
         else check("read", {pslverr, prdata}, rd_q.pop_front());
      end
      if (irq_accept === 1'h1) begin
         if (vec_q.size() == 0) check("accept", 33'h1, 33'h0);
         else check("vector", {16'h0, inhibit_flag, vector_addr},
                    {16'h0, 1'h1, vec_q.pop_front()});
      end
   end

   initial begin
      #2_000_000;
      num_errors++;
      complete_run;
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, event_in, timer_zero} = '0;
      {rx_loaded, tx_buf_empty, tx_shift_done, adc_done, go, kind, slow} = '0;
      {host_cs_n, host_wr_n, host_rd_n, host_a0} = 4'hF;
      ext_pin      = 3'h7;
      // idle high like the synchronisers after reset, so no false edge follows reset
      event_in     = 3'h7;
      host_data_in = 8'h00;
      num_errors   = 0;
      comparisons  = 0;
      seed         = 32'hA1BD4100;
      out_byte     = 8'($random(seed));
      in_byte      = 8'($random(seed));
      presetn      = 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, irq_ctrl_pkg::IDX_MISC, 8'h00, 33'h0);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h0);
      apb(1'h0, irq_ctrl_pkg::IDX_STATUS, 8'h00, 33'h4);
      apb(1'h0, irq_ctrl_pkg::IDX_VEC_HI, 8'h00, 33'hFF);
      apb(1'h0, 10'h3FF, 8'h00, 33'h100000000);
      @(posedge pclk) ext_pin <= 3'h0;
      repeat (6) @(posedge pclk);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h1C);
      apb(1'h1, irq_ctrl_pkg::IDX_MISC, 8'h01, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h0);
      @(posedge pclk) ext_pin <= 3'h7;
      repeat (6) @(posedge pclk);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h04);
      apb(1'h1, irq_ctrl_pkg::IDX_REQ_ONE, 8'hFF, 33'h0);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h04);
      apb(1'h1, irq_ctrl_pkg::IDX_MISC, 8'h00, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h0);
      pulse(3'h0, 4'hC);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_TWO, 8'h00, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_CTRL, 8'h38, 33'h0);
      pulse(3'h0, 4'h4);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_TWO, 8'h00, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_CTRL, 8'h30, 33'h0);
      pulse(3'h0, 4'h2);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_TWO, 8'h00, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_HOST_OUT, out_byte, 33'h0);
      pulse(3'h7, 4'hD);
      @(posedge pclk);
      event_in     <= 3'h0;
      ext_pin      <= 3'h0;
      host_data_in <= in_byte;
      host(1'h0);
      host(1'h1);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'hFF);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_TWO, 8'h00, 33'h3F);
      apb(1'h0, irq_ctrl_pkg::IDX_HOST_IN, 8'h00, {25'h0, in_byte});
      exec(2'h3);
      exec(2'h0);
      exec(2'h2);
      apb(1'h1, irq_ctrl_pkg::IDX_EN_TWO, 8'h20, 33'h0);
      exec(2'h0);
      exec(2'h3);
      vec_q.push_back(16'hFFE2);
      exec(2'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_EN_ONE, 8'hFF, 33'h0);
      apb(1'h1, irq_ctrl_pkg::IDX_EN_TWO, 8'h3F, 33'h0);
      for (int i = 0; i < 13; i++) begin
         vec_q.push_back(16'hFFFC - 16'(2 * i));
         exec(2'h3);
         exec(2'h0);
      end
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_ONE, 8'h00, 33'h0);
      apb(1'h0, irq_ctrl_pkg::IDX_REQ_TWO, 8'h00, 33'h0);
      vec_q.push_back(16'hFFE0);
      exec(2'h1);
      apb(1'h1, irq_ctrl_pkg::IDX_EN_ONE, 8'h00, 33'h0);
      pulse(3'h1, 4'h0);
      vec_q.push_back(16'hFFF2);
      exec(2'h1);
      pulse(3'h0, 4'h1);
      vec_q.push_back(16'hFFE2);
      exec(2'h1);
      exec(2'h3);
      apb(1'h0, irq_ctrl_pkg::IDX_STATUS, 8'h00, 33'h0);
      exec(2'h2);
      apb(1'h0, irq_ctrl_pkg::IDX_STATUS, 8'h00, 33'h4);
      check("pending", 33'(vec_q.size()), 33'h0);
      complete_run;
   end
endmodule // test_vectored_interrupt_control
